// File: design/dsre_params.svh
// Offsets, field positions and reset values of the debug service block.
// Assumes inclusion by bare name from any file that needs them.
`ifndef DSRE_PARAMS_SVH
`define DSRE_PARAMS_SVH

// ****************************************************************
// Register word offsets
// ****************************************************************
`define DSRE_OFS_CTRL      6'h00
`define DSRE_OFS_STATUS_A  6'h01
`define DSRE_OFS_STATUS_B  6'h02

// ****************************************************************
// Field positions
// ****************************************************************
`define DSRE_CTRL_ERASE     1
`define DSRE_STA_DONE       0
`define DSRE_STA_CPU_HOLD   1
`define DSRE_STA_PROT_ERR   4
`define DSRE_STB_PROT       0
`define DSRE_STB_PROBE      1
`define DSRE_STB_HP_AVAIL   2
`define DSRE_STB_BUSY       3

// ****************************************************************
// Reset values
// ****************************************************************
`define DSRE_PIN_IDLE      1'h1
`define DSRE_RDATA_RESET   32'h0000_0000

`endif

// File: design/dsre_pkg.sv
// Types shared by the debug service block and its erase sequencer.
// Assumes nothing of its surroundings.
`default_nettype none

package dsre_pkg;

   // Chip-erase steps, walked strictly in this order.
   typedef enum logic [1:0] {
      ERASE_IDLE  = 2'b00,
      ERASE_RAM   = 2'b01,
      ERASE_FLASH = 2'b10,
      ERASE_LOCK  = 2'b11
   } dsre_erase_state_t;

endpackage

`default_nettype wire

// File: design/dsre_sync.sv
// Two-flop synchroniser for levels arriving from outside the clock domain.
// Assumes the input is a slow level; pulses shorter than a clock are lost.
`default_nettype none

module dsre_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             clk,    // Block clock.
   input  wire logic             rst_b,  // Async reset, active low.
   input  wire logic [WIDTH-1:0] d,      // Asynchronous level.
   output logic      [WIDTH-1:0] q       // Synchronised level.
);

   logic [WIDTH-1:0] stage1;

   // The first stage feeds only the second, so metastability settles there.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         stage1 <= RESET_VAL;
         q      <= RESET_VAL;
      end else begin
         stage1 <= d;
         q      <= stage1;
      end
   end

endmodule

`default_nettype wire

// File: design/dsre_erase_seq.sv
// Chip-erase sequencer: volatile clear, flash array erase, lock row erase.
// Assumes each step_ack is a one-cycle pulse answering the raised request.
`default_nettype none

module dsre_erase_seq (
   input  wire logic clk,             // Block clock.
   input  wire logic rst_b,           // Async reset, active low.
   input  wire logic start,           // One-cycle start pulse.
   input  wire logic step_ack,        // Current step finished.
   output logic      ram_clear_req,   // Clear volatile memories.
   output logic      flash_erase_req, // Erase main flash array.
   output logic      lock_erase_req,  // Erase lock row.
   output logic      busy,            // Sequence in progress.
   output logic      finished         // One-cycle end pulse.
);

   dsre_pkg::dsre_erase_state_t state;
   dsre_pkg::dsre_erase_state_t next_state;

   // Steps advance only in the fixed order; no step is ever skipped.
   always_comb begin
      next_state = state;
      case (state)
         dsre_pkg::ERASE_IDLE: begin
            if (start) begin
               next_state = dsre_pkg::ERASE_RAM;
            end
         end
         dsre_pkg::ERASE_RAM: begin
            if (step_ack) begin
               next_state = dsre_pkg::ERASE_FLASH;
            end
         end
         dsre_pkg::ERASE_FLASH: begin
            if (step_ack) begin
               next_state = dsre_pkg::ERASE_LOCK;
            end
         end
         dsre_pkg::ERASE_LOCK: begin
            if (step_ack) begin
               next_state = dsre_pkg::ERASE_IDLE;
            end
         end
         default: begin
            next_state = dsre_pkg::ERASE_IDLE;
         end
      endcase
   end

   // Requests are registered from the next state so they track the state flop.
   // Auxiliary rows have no request at all, so they can never be erased here.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         state           <= dsre_pkg::ERASE_IDLE;
         ram_clear_req   <= 1'h0;
         flash_erase_req <= 1'h0;
         lock_erase_req  <= 1'h0;
         busy            <= 1'h0;
         finished        <= 1'h0;
      end else begin
         state           <= next_state;
         ram_clear_req   <= (next_state == dsre_pkg::ERASE_RAM);
         flash_erase_req <= (next_state == dsre_pkg::ERASE_FLASH);
         lock_erase_req  <= (next_state == dsre_pkg::ERASE_LOCK);
         busy            <= (next_state != dsre_pkg::ERASE_IDLE);
         finished        <= (state == dsre_pkg::ERASE_LOCK) && step_ack;
      end
   end

endmodule

`default_nettype wire

// File: design/dsre_service.sv
// Debug service block: reset extension, probe detection and chip-erase.
// Assumes an Avalon-MM master on clk and pins that are asynchronous to clk.
// Flash controller and access guard signals arrive on clk.
`include "dsre_params.svh"
`default_nettype none

// Function
// - Extend CPU reset when external reset releases with clock pin low.
// - Show cpu_hold_flag set while the CPU is held.
// - Writing one to cpu_hold_flag releases the CPU and clears it.
// - Writing zero to cpu_hold_flag changes nothing.
// - Release refused under security bit; sets protection_error_flag.
// - A reset extension request counts as a cold-plugged probe.
// - Hot-plug detector held in reset during power-on or external reset.
// - Outside reset, a falling clock pin edge detects a hot-plugged probe.
// - Pin reassignment or disabled pin select disables hot-plug until reset.
// - hot_plug_available reports current hot-plug availability.
// - Either detection sets probe_present_flag.
// - Security bit makes hot-plug unavailable; cold-plug remains.
// - No probe detection before power-on reset releases.
// - Writing one to erase_trigger starts chip-erase.
// - Chip-erase is ignored when access_guard write-protects the unit.
// - Erase clears volatile memory, then flash array, then lock row.
// - Chip-erase leaves auxiliary rows and user row untouched.
// - Done flag set when erase ends; debugger polls it.
// - access_guard does not protect debugger accesses or channel registers.
module dsre_service (
   input  wire logic        clk,             // Bus clock, 125 MHz.
   input  wire logic        rst_b,           // Power-on reset, async, low.
   input  wire logic        ext_reset_b,     // External reset pin, low.
   input  wire logic        swclk,           // Serial-wire clock pin.
   input  wire logic        security_bit,    // Flash security bit set.
   input  wire logic        swclk_is_debug,  // Clock pad on debug function.
   input  wire logic        pin_select_en,   // Pin function select enabled.
   input  wire logic        guard_lock,      // Write protect by guard.
   input  wire logic        step_ack,        // Erase step finished pulse.
   input  wire logic        dbg_access,      // Request from debugger.
   input  wire logic [7:0]  avs_address,     // Byte address.
   input  wire logic        avs_read,        // Read request.
   input  wire logic        avs_write,       // Write request.
   input  wire logic [31:0] avs_writedata,   // Write data.
   input  wire logic [3:0]  avs_byteenable,  // Byte lanes.
   output logic      [31:0] avs_readdata,    // Read data.
   output logic             avs_waitrequest, // Stall, active high.
   output logic             cpu_reset_hold,  // CPU kept in reset.
   output logic             ram_clear_req,   // Clear volatile memory.
   output logic             flash_erase_req, // Erase flash array.
   output logic             lock_erase_req   // Erase lock row.
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************

   logic ext_rst_s;
   logic ext_rst_d;
   logic swclk_s;
   logic swclk_d;

   // Reset value of the external reset path is "released", so leaving
   // power-on reset never fakes a release edge.
   dsre_sync #(
      .WIDTH     (1),
      .RESET_VAL (`DSRE_PIN_IDLE)
   ) u_sync_rst (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (ext_reset_b),
      .q     (ext_rst_s)
   );

   // The clock pad is pulled up, so its idle value is high.
   dsre_sync #(
      .WIDTH     (1),
      .RESET_VAL (`DSRE_PIN_IDLE)
   ) u_sync_swclk (
      .clk   (clk),
      .rst_b (rst_b),
      .d     (swclk),
      .q     (swclk_s)
   );

   // ****************************************************************
   // Edge detection
   // ****************************************************************

   logic ext_in_reset;
   logic ext_release;
   logic swclk_fall;
   logic cold_plug;

   // Delayed copies of the synchronised pins for edge detection.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ext_rst_d <= `DSRE_PIN_IDLE;
         swclk_d   <= `DSRE_PIN_IDLE;
      end else begin
         ext_rst_d <= ext_rst_s;
         swclk_d   <= swclk_s;
      end
   end

   // Nothing here runs before power-on reset is gone, as all flops are held.
   assign ext_in_reset = ~ext_rst_s;
   assign ext_release  = ext_rst_s & ~ext_rst_d;
   assign swclk_fall   = swclk_d & ~swclk_s;
   // Release must see the pin still low.
   assign cold_plug    = ext_release & ~swclk_s;

   // ****************************************************************
   // Avalon-MM handshake
   // ****************************************************************

   logic bus_req;
   logic bus_wr;
   logic bus_rd;
   logic wr_allowed;
   logic byte0;
   logic [5:0] word;

   assign bus_req = avs_read | avs_write;

   // Every access gets exactly one wait cycle, so timing never depends on
   // the register addressed.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_waitrequest <= 1'h1;
      end else if (bus_req && avs_waitrequest) begin
         avs_waitrequest <= 1'h0;
      end else begin
         avs_waitrequest <= 1'h1;
      end
   end

   // A write acts on the edge where the master sees waitrequest low.
   assign bus_wr = avs_write & ~avs_waitrequest;
   // Read data load on the request edge.
   assign bus_rd = avs_read & avs_waitrequest;
   assign word   = avs_address[7:2];
   assign byte0  = avs_byteenable[0];

   // Debugger accesses bypass the guard; the internal side is locked out.
   // Guard covers erase and release.
   assign wr_allowed = dbg_access | ~guard_lock;

   // ****************************************************************
   // Write strobes
   // ****************************************************************

   logic wr_ctrl;
   logic wr_sta;
   logic erase_start;
   logic hold_release;
   logic hold_refused;
   logic protection_error_flag_clear;

   // Only byte lane zero carries control bits.
   assign wr_ctrl = bus_wr & byte0 & wr_allowed & (word == `DSRE_OFS_CTRL);
   assign wr_sta  = bus_wr & byte0 & wr_allowed & (word == `DSRE_OFS_STATUS_A);

   // ****************************************************************
   // Chip-erase
   // ****************************************************************

   logic erase_busy;
   logic erase_finished;
   logic done;

   // A start while a sequence runs is dropped rather than queued.
   assign erase_start = wr_ctrl & avs_writedata[`DSRE_CTRL_ERASE]
                        & ~erase_busy;

   dsre_erase_seq u_erase (
      .clk             (clk),
      .rst_b           (rst_b),
      .start           (erase_start),
      .step_ack        (step_ack),
      .ram_clear_req   (ram_clear_req),
      .flash_erase_req (flash_erase_req),
      .lock_erase_req  (lock_erase_req),
      .busy            (erase_busy),
      .finished        (erase_finished)
   );

   // Done is cleared by a new start and by either reset; completion wins.
   // Busy is already low at finished, so a start can land with it and done stays set.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         done <= 1'h0;
      end else if (erase_finished) begin
         done <= 1'h1;
      end else if (ext_in_reset || erase_start) begin
         done <= 1'h0;
      end
   end

   // ****************************************************************
   // CPU reset extension
   // ****************************************************************

   logic cpu_hold;
   logic prot_err;

   // Writing zero to the hold bit leaves everything alone.
   assign hold_release = wr_sta & avs_writedata[`DSRE_STA_CPU_HOLD];
   assign hold_refused = hold_release & security_bit;
   assign protection_error_flag_clear   = wr_sta & avs_writedata[`DSRE_STA_PROT_ERR];

   // Hold is taken at reset release with the clock pin low and dropped by an
   // accepted release write or by the external reset.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu_hold <= 1'h0;
      end else if (ext_in_reset) begin
         cpu_hold <= 1'h0;
      end else if (cold_plug) begin
         cpu_hold <= 1'h1;
      end else if (hold_release && !security_bit) begin
         cpu_hold <= 1'h0;
      end
   end

   // Protection error is sticky; a refused release beats a clear.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prot_err <= 1'h0;
      end else if (hold_refused) begin
         prot_err <= 1'h1;
      end else if (ext_in_reset || protection_error_flag_clear) begin
         prot_err <= 1'h0;
      end
   end

   // The CPU sits in reset through the external reset and the extension.
   // Cold plug is ORed in: the hold flag
   // rises an edge later, so no gap is left.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cpu_reset_hold <= 1'h1;
      end else begin
         cpu_reset_hold <= ext_in_reset
                           | cold_plug
                           | cpu_hold;
      end
   end

   // ****************************************************************
   // Probe detection
   // ****************************************************************

   logic hp_lost;
   logic hp_avail;
   logic next_hp_avail;
   logic probe;

   // Once the pad leaves the debug function, hot-plug stays off until a
   // reset, even if software hands the pad back.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hp_lost <= 1'h0;
      end else if (ext_in_reset) begin
         hp_lost <= 1'h0;
      end else if (!swclk_is_debug || !pin_select_en) begin
         hp_lost <= 1'h1;
      end
   end

   // Detector is off in reset and on a secured part.
   assign next_hp_avail = ~ext_in_reset
                          & ~hp_lost
                          & ~security_bit;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         hp_avail <= 1'h0;
      end else begin
         hp_avail <= next_hp_avail;
      end
   end

   // Both detection paths set the probe flag; only reset clears it.
   // A set beats a clear in one cycle.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         probe <= 1'h0;
      end else if (cold_plug) begin
         probe <= 1'h1;
      end else if (swclk_fall && hp_avail && next_hp_avail) begin
         probe <= 1'h1;
      end else if (ext_in_reset) begin
         probe <= 1'h0;
      end
   end

   // ****************************************************************
   // Read data
   // ****************************************************************

   logic [31:0] next_rdata;

   // Unmapped words and reserved bits read as zero.
   always_comb begin
      next_rdata = `DSRE_RDATA_RESET;
      case (word)
         `DSRE_OFS_STATUS_A: begin
            next_rdata[`DSRE_STA_DONE]     = done;
            next_rdata[`DSRE_STA_CPU_HOLD] = cpu_hold;
            next_rdata[`DSRE_STA_PROT_ERR] = prot_err;
         end
         `DSRE_OFS_STATUS_B: begin
            next_rdata[`DSRE_STB_PROT]     = security_bit;
            next_rdata[`DSRE_STB_PROBE]    = probe;
            next_rdata[`DSRE_STB_HP_AVAIL] = hp_avail;
            next_rdata[`DSRE_STB_BUSY]     = erase_busy;
         end
         default: begin
            next_rdata = `DSRE_RDATA_RESET;
         end
      endcase
   end

   // Read data is captured as the request arrives and held for the answer.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         avs_readdata <= `DSRE_RDATA_RESET;
      end else if (bus_rd) begin
         avs_readdata <= next_rdata;
      end
   end

endmodule

`default_nettype wire

// File: tb/dsre_service_properties.sv
// Port checks on the debug service block.
// Assumes dsre_params.svh.
`include "dsre_params.svh"
`default_nettype none
module dsre_service_properties (
   input wire logic        clk,             // Clock.
   input wire logic        rst_b,           // Reset.
   input wire logic        ext_reset_b,     // Pin reset.
   input wire logic        swclk,           // Pin clock.
   input wire logic        security_bit,    // Secured.
   input wire logic        guard_lock,      // Guarded.
   input wire logic        step_ack,        // Step done.
   input wire logic        dbg_access,      // Debugger.
   input wire logic [7:0]  avs_address,     // Address.
   input wire logic        avs_write,       // Write.
   input wire logic [31:0] avs_writedata,   // Data.
   input wire logic [3:0]  avs_byteenable,  // Lanes.
   input wire logic        avs_waitrequest, // Stall.
   input wire logic        cpu_reset_hold,  // CPU held.
   input wire logic        ram_clear_req,   // RAM step.
   input wire logic        flash_erase_req, // Flash step.
   input wire logic        lock_erase_req   // Lock step.
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   // ********
   // Accepted writes
   // ********
   logic wr_go, ctl_hit, sta_hit, any_req;
   // Writes that the design will accept.
   assign wr_go   = avs_write && !avs_waitrequest && avs_byteenable[0] && ext_reset_b
                    && (dbg_access || !guard_lock);
   assign ctl_hit = wr_go && avs_address[7:2] == `DSRE_OFS_CTRL
                    && avs_writedata[`DSRE_CTRL_ERASE];
   assign sta_hit = wr_go && avs_address[7:2] == `DSRE_OFS_STATUS_A;
   assign any_req = ram_clear_req | flash_erase_req | lock_erase_req;
   property p_erase_start;
      ctl_hit && !any_req |=> ram_clear_req;
   endproperty
   a_erase_start: assert property (p_erase_start) else $error("erase did not start");
   property p_guard_block;
      avs_write && !avs_waitrequest && !dbg_access && guard_lock && !any_req
      && avs_address[7:2] == `DSRE_OFS_CTRL |=> !ram_clear_req;
   endproperty
   a_guard_block: assert property (p_guard_block) else $error("guarded erase ran");
   property p_flash_after_ram;
      $rose(flash_erase_req) |-> $past(ram_clear_req) && $past(step_ack);
   endproperty
   a_flash_after_ram: assert property (p_flash_after_ram) else $error("flash out of order");
   property p_lock_after_flash;
      $rose(lock_erase_req) |-> $past(flash_erase_req) && $past(step_ack);
   endproperty
   a_lock_after_flash: assert property (p_lock_after_flash) else $error("lock out of order");
   property p_one_step;
      $onehot0({ram_clear_req, flash_erase_req, lock_erase_req});
   endproperty
   a_one_step: assert property (p_one_step) else $error("two erase steps at once");
   property p_cold_hold;
      $rose(ext_reset_b) && !swclk && !$past(swclk) |=> cpu_reset_hold [*8];
   endproperty
   a_cold_hold: assert property (p_cold_hold) else $error("cpu not held");
   property p_release;
      sta_hit && avs_writedata[`DSRE_STA_CPU_HOLD] && !security_bit |-> ##2 !cpu_reset_hold;
   endproperty
   a_release: assert property (p_release) else $error("cpu not released");
   property p_refuse;
      sta_hit && avs_writedata[`DSRE_STA_CPU_HOLD] && security_bit && cpu_reset_hold
      |=> cpu_reset_hold [*4];
   endproperty
   a_refuse: assert property (p_refuse) else $error("release not refused");
   property p_zero_write;
      sta_hit && !avs_writedata[`DSRE_STA_CPU_HOLD] && cpu_reset_hold |=> cpu_reset_hold [*3];
   endproperty
   a_zero_write: assert property (p_zero_write) else $error("zero write released cpu");
   c_erase_end: cover property (lock_erase_req && step_ack);
   c_cold: cover property ($rose(ext_reset_b) && !swclk);
   c_refuse: cover property (sta_hit && security_bit);
endmodule
bind dsre_service dsre_service_properties i_props (.clk(clk), .rst_b(rst_b),
   .ext_reset_b(ext_reset_b), .swclk(swclk), .security_bit(security_bit),
   .guard_lock(guard_lock), .step_ack(step_ack), .dbg_access(dbg_access),
   .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
   .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
   .cpu_reset_hold(cpu_reset_hold), .ram_clear_req(ram_clear_req),
   .flash_erase_req(flash_erase_req), .lock_erase_req(lock_erase_req));
`default_nettype wire

// File: tb/dsre_probe.sv
// Model of the external debug adapter: reset pin and serial-wire clock.
// Assumes callers enter its tasks just after a rising edge of clk.
`default_nettype none
module dsre_probe (
   input  wire logic clk,         // Block clock, aligns pin changes.
   output var  logic ext_reset_b, // External reset pin, active low.
   output var  logic swclk        // Serial-wire clock, idle high.
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle: reset released, clock high.
   initial begin
      ext_reset_b = 1'b1;
      swclk       = 1'b1;
   end
   // Cold plug: clock low across the reset release.
   task automatic cold_plug();
      ext_reset_b <= 1'b0;
      swclk       <= 1'b0;
      repeat (12) @(posedge clk);
      ext_reset_b <= 1'b1;
      repeat (12) @(posedge clk);
      swclk <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
   // n periods of 80 ns; idle high between.
   task automatic frame(input int n);
      repeat (n) begin
         swclk <= 1'b0;
         repeat (5) @(posedge clk);
         swclk <= 1'b1;
         repeat (5) @(posedge clk);
      end
   endtask
   // Reset with the clock high: no extension.
   task automatic reset_pulse();
      ext_reset_b <= 1'b0;
      repeat (8) @(posedge clk);
      ext_reset_b <= 1'b1;
      repeat (6) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// File: tb/dsre_service_tb.sv
// Self-checking bench for the debug service block.
// Assumes the probe model drives the pins.
`include "dsre_params.svh"
`default_nettype none
module dsre_service_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_b, ext_reset_b, swclk, security_bit, swclk_is_debug;
   logic        pin_select_en, guard_lock, step_ack, dbg_access, avs_read, avs_write;
   logic        avs_waitrequest, cpu_reset_hold, ram_clear_req, flash_erase_req;
   logic        lock_erase_req;
   logic [7:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   int          mismatches, samples_checked, e_hold, e_protection_error_flag, e_done, e_probe, e_hp;
   int          steps[$];
   localparam logic [7:0] sta_a = {`DSRE_OFS_STATUS_A, 2'b00};
   dsre_service i_dut (.clk(clk), .rst_b(rst_b), .ext_reset_b(ext_reset_b), .swclk(swclk),
      .security_bit(security_bit), .swclk_is_debug(swclk_is_debug),
      .pin_select_en(pin_select_en), .guard_lock(guard_lock), .step_ack(step_ack),
      .dbg_access(dbg_access), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .cpu_reset_hold(cpu_reset_hold), .ram_clear_req(ram_clear_req),
      .flash_erase_req(flash_erase_req), .lock_erase_req(lock_erase_req));
   dsre_probe i_probe (.clk(clk), .ext_reset_b(ext_reset_b), .swclk(swclk));
   // Verdict; every exit comes here.
   task automatic close_out();
      $display("compared %0d, mismatched %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One transfer, held until waitrequest is low.
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n = 0;
      avs_address   <= a;
      avs_writedata <= d;
      avs_write     <= wr;
      avs_read      <= !wr;
      do begin
         @(posedge clk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 20);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      if (n >= 20) begin
         mismatches++;
         close_out();
      end
      @(posedge clk);
   endtask
   // Status words and hold pin vs model.
   task automatic chk_regs();
      logic [31:0] q, v;
      v = '0;
      v[`DSRE_STA_DONE]     = e_done[0];
      v[`DSRE_STA_CPU_HOLD] = e_hold[0];
      v[`DSRE_STA_PROT_ERR] = e_protection_error_flag[0];
      bus(1'b0, sta_a, '0, q);
      chk(q, v);
      v = '0;
      v[`DSRE_STB_PROT]     = security_bit;
      v[`DSRE_STB_PROBE]    = e_probe[0];
      v[`DSRE_STB_HP_AVAIL] = e_hp[0];
      bus(1'b0, {`DSRE_OFS_STATUS_B, 2'b00}, '0, q);
      chk(q, v);
      chk({31'h0, cpu_reset_hold}, e_hold);
   endtask
   // Clock at 125 MHz.
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // Flash side: log each step, ack after a random delay.
   initial begin
      step_ack = 1'b0;
      forever begin
         @(posedge clk);
         if ((ram_clear_req | flash_erase_req | lock_erase_req) === 1'b1 && !step_ack) begin
            steps.push_back(ram_clear_req ? 1 : flash_erase_req ? 2 : 3);
            repeat ($urandom_range(4)) @(posedge clk);
            step_ack <= 1'b1;
            @(posedge clk);
            step_ack <= 1'b0;
         end
      end
   end
   // Main sequence.
   initial begin
      logic [31:0] q;
      logic [7:0]  a;
      int          n;
      {rst_b, security_bit, guard_lock, dbg_access, avs_read, avs_write} = '0;
      {swclk_is_debug, pin_select_en} = 2'b11;
      {avs_address, avs_writedata} = '0;
      e_hp = 1;
      void'($urandom(79077));
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      chk_regs();
      a = {6'h03 + 6'($urandom_range(60)), 2'b00};
      bus(1'b1, a, $urandom, q);
      bus(1'b0, a, '0, q);
      chk(q, '0);
      $display("test 1 done");
      i_probe.frame(3);
      e_probe = 1;
      chk_regs();
      i_probe.reset_pulse();
      e_probe = 0;
      chk_regs();
      $display("test 2 done");
      security_bit <= 1'b1;
      e_hp = 0;
      i_probe.frame(2);
      chk_regs();
      i_probe.cold_plug();
      e_hold = 1;
      e_probe = 1;
      chk_regs();
      bus(1'b1, sta_a, 32'h0000_0002, q);
      e_protection_error_flag = 1;
      chk_regs();
      bus(1'b1, sta_a, 32'h0000_0000, q);
      chk_regs();
      security_bit <= 1'b0;
      e_hp = 1;
      bus(1'b1, sta_a, 32'h0000_0012, q);
      e_hold = 0;
      e_protection_error_flag = 0;
      chk_regs();
      $display("test 3 done");
      for (n = 0; n < 2; n++) begin
         if (n == 0) swclk_is_debug <= 1'b0;
         else pin_select_en <= 1'b0;
         @(posedge clk);
         {swclk_is_debug, pin_select_en} <= 2'b11;
         e_hp = 0;
         i_probe.frame(2);
         chk_regs();
         i_probe.reset_pulse();
         e_hp = 1;
         e_probe = 0;
         chk_regs();
      end
      $display("test 4 done");
      guard_lock <= 1'b1;
      bus(1'b1, {`DSRE_OFS_CTRL, 2'b00}, 32'h0000_0002, q);
      repeat (4) @(posedge clk);
      chk(steps.size(), 0);
      dbg_access <= 1'b1;
      bus(1'b1, {`DSRE_OFS_CTRL, 2'b00}, 32'h0000_0002, q);
      dbg_access <= 1'b0;
      n = 0;
      do begin
         bus(1'b0, sta_a, '0, q);
         n++;
      end while (q[`DSRE_STA_DONE] !== 1'b1 && n < 40);
      if (n >= 40) begin
         mismatches++;
         close_out();
      end
      e_done = 1;
      chk_regs();
      chk(steps.size(), 3);
      foreach (steps[i]) chk(steps[i], i + 1);
      guard_lock <= 1'b0;
      i_probe.reset_pulse();
      e_done = 0;
      chk_regs();
      $display("test 5 done");
      close_out();
   end
endmodule
`default_nettype wire
